/* File: common/sdrrpm_pkg.sv */
// Package with commands, timing constants and states of the refresh and power-down controller
`default_nettype none
package sdrrpm_pkg;
  // Clock period in picoseconds (50 MHz)
  localparam int CLK_PERIOD_PS = 20000;
  // Refresh budget: rows per interval, interval in ms
  localparam int REFRESH_ROWS = 4096;
  localparam int REFRESH_INTERVAL_MS = 64;
  localparam int REFRESH_INTERVAL_PS_PER_ROW = (REFRESH_INTERVAL_MS * 1000000) / REFRESH_ROWS;
  // Longest spacing between refreshes, rounded down: 15625 ns -> 781 cycles
  localparam int REFRESH_GAP_CYC = (REFRESH_INTERVAL_PS_PER_ROW * 1000) / CLK_PERIOD_PS;
  // Refresh cycle time in ns (row cycle time figure, slower grade)
  localparam int REFRESH_CYCLE_TIME_NS = 70;
  localparam int MODE_SET_WAIT_NS = 20;
  localparam int SELF_REFRESH_EXIT_WAIT_NS = 10;
  localparam int POWER_DOWN_EXIT_WAIT_NS = 10;
  localparam int ACTIVATE_SPACING_NS = 20;
  // Least times rounded up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc
  localparam int REFRESH_CYCLE_CYC = ns_to_cyc(REFRESH_CYCLE_TIME_NS);
  localparam int MODE_SET_WAIT_CYC = ns_to_cyc(MODE_SET_WAIT_NS);
  localparam int SELF_REFRESH_EXIT_CYC = ns_to_cyc(SELF_REFRESH_EXIT_WAIT_NS);
  localparam int POWER_DOWN_EXIT_CYC = ns_to_cyc(POWER_DOWN_EXIT_WAIT_NS);
  localparam int ACTIVATE_SPACING_CYC = ns_to_cyc(ACTIVATE_SPACING_NS);
  // Command pin codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESELECT = 4'hF;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  // User request codes
  localparam logic [2:0] REQ_NOP = 3'h0;
  localparam logic [2:0] REQ_ACTIVATE = 3'h1;
  localparam logic [2:0] REQ_READ = 3'h2;
  localparam logic [2:0] REQ_WRITE = 3'h3;
  localparam logic [2:0] REQ_PRECHARGE = 3'h4;
  localparam logic [2:0] REQ_MODE_SET = 3'h5;
  // Widths
  localparam int ADDR_W = 12;
  localparam int BANK_W = 2;
  localparam int DATA_W = 64;
  localparam int MASK_W = 8;
  localparam int WAIT_W = 12;
  // Controller states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_REFRESH = 7'h02,
    ST_SELF_REFRESH = 7'h04,
    ST_SR_EXIT = 7'h08,
    ST_POWER_DOWN = 7'h10,
    ST_PD_EXIT = 7'h20,
    ST_WAIT = 7'h40
  } sdrrpm_state_e;
endpackage : sdrrpm_pkg
`default_nettype wire

/* File: hw/sdrrpm_wait_timer.sv */
// Down-counter that holds off new commands for a loaded number of cycles
`default_nettype none
module sdrrpm_wait_timer (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [sdrrpm_pkg::WAIT_W-1:0] count_in,
  output logic busy_out
);
  logic [sdrrpm_pkg::WAIT_W-1:0] count_r;
  logic [sdrrpm_pkg::WAIT_W-1:0] count_nxt;

  // Load wins over counting down
  assign count_nxt = load_in ? count_in :
                     (count_r != '0) ? count_r - 12'h001 : count_r;

  // Counter register
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign busy_out = (count_r != '0);
endmodule : sdrrpm_wait_timer
`default_nettype wire

/* File: hw/sdrrpm_ctrl.sv */
// Host controller for refresh, self-refresh, power-down and byte masks of an SDRAM module
//
// Overview of operation
// - Device makes refresh row; controller issues 4096 auto-refreshes per 64 ms except while in power-down or self-refresh.
// - Controller issues auto-refresh only once the user has precharged every bank.
// - After auto-refresh, wait refresh cycle time before any command.
// - Self-refresh entry: cs, ras, cas low, we high, clock-gate low.
// - Exit self-refresh: stable clock, deselect or nop, then raise clock-gate.
// - After clock-gate rise, only deselect or nop for refresh cycle time.
// - After mode register set wait mode_set_wait before next command.
// - After self-refresh exit wait self_refresh_exit_wait before next command.
// - After power-down exit wait power_down_exit_wait before next command.
// - Space activates to different banks by activate_spacing.
// - Auto-refresh: cs, ras, cas low, we and clock-gate high.
// - Power-down or self-refresh only when every bank is idle; controller enforces it for self-refresh only.
`default_nettype none
module sdrrpm_ctrl (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [2:0] req_cmd_in,
  input wire logic req_valid_in,
  input wire logic [sdrrpm_pkg::BANK_W-1:0] req_bank_in,
  input wire logic [sdrrpm_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [sdrrpm_pkg::DATA_W-1:0] wr_data_in,
  input wire logic [sdrrpm_pkg::MASK_W-1:0] wr_mask_in,
  input wire logic [sdrrpm_pkg::MASK_W-1:0] rd_mask_in,
  input wire logic self_refresh_req_in,
  input wire logic power_down_req_in,
  input wire logic [sdrrpm_pkg::DATA_W-1:0] dq_in,
  output logic req_ready_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic cke_out,
  output logic [sdrrpm_pkg::BANK_W-1:0] ba_out,
  output logic [sdrrpm_pkg::ADDR_W-1:0] addr_out,
  output logic [sdrrpm_pkg::MASK_W-1:0] byte_lane_mask_out,
  output logic [sdrrpm_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  output logic [sdrrpm_pkg::DATA_W-1:0] rd_data_out,
  output logic in_self_refresh_out,
  output logic in_power_down_out
);
  // Counter runs from GAP down to zero, so one period is REFRESH_GAP_CYC cycles
  localparam logic [11:0] GAP = 12'(sdrrpm_pkg::REFRESH_GAP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State and registers
  sdrrpm_pkg::sdrrpm_state_e state_r, state_nxt;
  logic [11:0] gap_r;
  logic refresh_due_r;
  logic [3:0] cmd_r, cmd_nxt;
  logic cke_r, cke_nxt;
  logic [1:0] ba_r;
  logic [11:0] addr_r;
  logic [7:0] mask_r;
  logic [63:0] dq_r;
  logic dq_oe_r;
  logic ready_r;
  logic in_sr_r;
  logic in_pd_r;
  logic [63:0] rd_data_r;
  logic [3:0] open_banks_r;
  logic act_busy;
  logic wait_busy;
  logic timer_load;
  logic [11:0] timer_count;

  // Decoded request conditions
  wire all_idle = (open_banks_r == 4'h0);
  wire take_req = req_valid_in && ready_r;
  wire is_act = take_req && (req_cmd_in == sdrrpm_pkg::REQ_ACTIVATE);
  wire in_idle = (state_r == sdrrpm_pkg::ST_IDLE);
  wire idle_free = in_idle && !wait_busy;
  wire go_refresh = idle_free && refresh_due_r && all_idle;
  wire go_self = idle_free && !refresh_due_r && all_idle && self_refresh_req_in;
  wire go_pd = idle_free && !refresh_due_r && !self_refresh_req_in && power_down_req_in;

  ////////////////////////////////////////////////////////////////////////////
  // Hold-off timer shared by all command-interval limits except activate spacing
  sdrrpm_wait_timer u_wait (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .load_in(timer_load),
    .count_in(timer_count),
    .busy_out(wait_busy)
  );

  // Separate timer for bank-to-bank activate spacing
  sdrrpm_wait_timer u_act (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .load_in(cmd_nxt == sdrrpm_pkg::CMD_ACTIVATE),
    .count_in(12'(sdrrpm_pkg::ACTIVATE_SPACING_CYC)),
    .busy_out(act_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state and command selection
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = sdrrpm_pkg::CMD_NOP;
    cke_nxt = cke_r;
    timer_load = 1'b0;
    timer_count = '0;
    case (state_r)
      sdrrpm_pkg::ST_IDLE: begin
        if (go_refresh) begin
          cmd_nxt = sdrrpm_pkg::CMD_REFRESH;
          state_nxt = sdrrpm_pkg::ST_REFRESH;
          timer_load = 1'b1;
          timer_count = 12'(sdrrpm_pkg::REFRESH_CYCLE_CYC);
        end else if (go_self) begin
          cmd_nxt = sdrrpm_pkg::CMD_REFRESH;
          cke_nxt = 1'b0;
          state_nxt = sdrrpm_pkg::ST_SELF_REFRESH;
        end else if (go_pd) begin
          cke_nxt = 1'b0;
          state_nxt = sdrrpm_pkg::ST_POWER_DOWN;
        end else if (take_req && !wait_busy && !(is_act && act_busy)) begin
          case (req_cmd_in)
            sdrrpm_pkg::REQ_ACTIVATE: cmd_nxt = sdrrpm_pkg::CMD_ACTIVATE;
            sdrrpm_pkg::REQ_READ: cmd_nxt = sdrrpm_pkg::CMD_READ;
            sdrrpm_pkg::REQ_WRITE: cmd_nxt = sdrrpm_pkg::CMD_WRITE;
            sdrrpm_pkg::REQ_PRECHARGE: cmd_nxt = sdrrpm_pkg::CMD_PRECHARGE;
            sdrrpm_pkg::REQ_MODE_SET: begin
              cmd_nxt = sdrrpm_pkg::CMD_MODE_SET;
              timer_load = 1'b1;
              timer_count = 12'(sdrrpm_pkg::MODE_SET_WAIT_CYC);
            end
            default: cmd_nxt = sdrrpm_pkg::CMD_NOP;
          endcase
        end
      end
      sdrrpm_pkg::ST_REFRESH: begin
        if (!wait_busy) begin
          state_nxt = sdrrpm_pkg::ST_IDLE;
        end
      end
      sdrrpm_pkg::ST_SELF_REFRESH: begin
        cmd_nxt = sdrrpm_pkg::CMD_DESELECT;
        // Deselect must already stand on the pins before the clock gate rises
        if (!self_refresh_req_in && (cmd_r == sdrrpm_pkg::CMD_DESELECT)) begin
          cke_nxt = 1'b1;
          state_nxt = sdrrpm_pkg::ST_SR_EXIT;
          timer_load = 1'b1;
          timer_count = 12'(sdrrpm_pkg::REFRESH_CYCLE_CYC + sdrrpm_pkg::SELF_REFRESH_EXIT_CYC);
        end
      end
      sdrrpm_pkg::ST_SR_EXIT: begin
        cmd_nxt = sdrrpm_pkg::CMD_DESELECT;
        if (!wait_busy && !timer_load) begin
          state_nxt = sdrrpm_pkg::ST_IDLE;
        end
      end
      sdrrpm_pkg::ST_POWER_DOWN: begin
        if (!power_down_req_in) begin
          cke_nxt = 1'b1;
          state_nxt = sdrrpm_pkg::ST_PD_EXIT;
          timer_load = 1'b1;
          timer_count = 12'(sdrrpm_pkg::POWER_DOWN_EXIT_CYC);
        end
      end
      sdrrpm_pkg::ST_PD_EXIT: begin
        if (!wait_busy) begin
          state_nxt = sdrrpm_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = sdrrpm_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh interval counter; set of the due flag wins over its clear
  wire refresh_issued = go_refresh;
  wire gap_done = (gap_r == 12'h000);
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      gap_r <= GAP;
      refresh_due_r <= 1'b0;
    end else begin
      gap_r <= gap_done ? GAP : gap_r - 12'h001;
      refresh_due_r <= gap_done | (refresh_due_r & ~refresh_issued);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank open tracking; self-refresh wakes with all banks idle
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      open_banks_r <= 4'h0;
    end else if (cmd_nxt == sdrrpm_pkg::CMD_ACTIVATE) begin
      open_banks_r <= open_banks_r | (4'h1 << req_bank_in);
    end else if (cmd_nxt == sdrrpm_pkg::CMD_PRECHARGE) begin
      open_banks_r <= req_addr_in[10] ? 4'h0 : (open_banks_r & ~(4'h1 << req_bank_in));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers: command, address, clock gate, masks and write data
  wire drive_addr = (cmd_nxt != sdrrpm_pkg::CMD_NOP) && (cmd_nxt != sdrrpm_pkg::CMD_DESELECT);
  wire issue_wr = (cmd_nxt == sdrrpm_pkg::CMD_WRITE);
  // Requests stay open while a bank is open, so the user can still precharge
  wire sleep_or_ref = (refresh_due_r || self_refresh_req_in) && all_idle;
  wire may_take = in_idle && !wait_busy && !sleep_or_ref && !power_down_req_in && cke_r;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_r <= sdrrpm_pkg::ST_IDLE;
      cmd_r <= sdrrpm_pkg::CMD_NOP;
      cke_r <= 1'b1;
      ba_r <= '0;
      addr_r <= '0;
      mask_r <= 8'hFF;
      dq_r <= '0;
      dq_oe_r <= 1'b0;
      ready_r <= 1'b0;
      in_sr_r <= 1'b0;
      in_pd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      cke_r <= cke_nxt;
      ba_r <= drive_addr ? req_bank_in : ba_r;
      addr_r <= drive_addr ? req_addr_in : addr_r;
      mask_r <= issue_wr ? wr_mask_in : rd_mask_in;
      dq_r <= wr_data_in;
      dq_oe_r <= issue_wr;
      ready_r <= may_take;
      in_sr_r <= (state_nxt == sdrrpm_pkg::ST_SELF_REFRESH);
      in_pd_r <= (state_nxt == sdrrpm_pkg::ST_POWER_DOWN);
    end
  end

  // Read data capture; masked lanes are floating at the pins two cycles on
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= dq_in;
    end
  end

  assign req_ready_out = ready_r;
  assign {cs_n_out, ras_n_out, cas_n_out, we_n_out} = cmd_r;
  assign cke_out = cke_r;
  assign ba_out = ba_r;
  assign addr_out = addr_r;
  assign byte_lane_mask_out = mask_r;
  assign dq_out = dq_r;
  assign dq_oe_out = dq_oe_r;
  assign rd_data_out = rd_data_r;
  assign in_self_refresh_out = in_sr_r;
  assign in_power_down_out = in_pd_r;
endmodule : sdrrpm_ctrl
`default_nettype wire

/* File: verif/sdrrpm_ctrl_assertions.sv */
// Checker of command timing at the controller pins
`default_nettype none
module sdrrpm_ctrl_assertions (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic cs_n_out,
  input wire logic ras_n_out,
  input wire logic cas_n_out,
  input wire logic we_n_out,
  input wire logic cke_out,
  input wire logic [1:0] ba_out,
  input wire logic [11:0] addr_out,
  input wire logic dq_oe_out,
  input wire logic in_self_refresh_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  logic [3:0] cmd;
  logic [3:0] open_r;
  logic sr_r;
  logic [9:0] gap_r;
  logic quiet;
  logic is_ref;
  // Pin decode
  assign cmd = {cs_n_out, ras_n_out, cas_n_out, we_n_out};
  assign quiet = cmd[3] || cmd == sdrrpm_pkg::CMD_NOP;
  assign is_ref = cmd == sdrrpm_pkg::CMD_REFRESH;
  // Open banks, self-refresh mark, cycles since the last refresh
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      open_r <= 4'h0;
      sr_r <= 1'b0;
      gap_r <= 10'h000;
    end else begin
      if (cmd == sdrrpm_pkg::CMD_ACTIVATE) open_r[ba_out] <= 1'b1;
      else if (cmd == sdrrpm_pkg::CMD_PRECHARGE)
        open_r <= addr_out[10] ? 4'h0 : open_r & ~(4'h1 << ba_out);
      sr_r <= !cke_out && (is_ref || sr_r);
      gap_r <= (is_ref || !cke_out) ? 10'h000 : gap_r + 10'h001;
    end
  end
  sequence rest4_s;
    quiet [*4];
  endsequence
  sequence rest5_s;
    quiet [*5];
  endsequence
  a_refresh_gap: assert property (gap_r < 10'h384)
    else $error("refresh gap too long");
  a_refresh_idle: assert property (is_ref |-> open_r == 4'h0)
    else $error("refresh with a bank open");
  a_refresh_rest: assert property (is_ref && cke_out |=> rest4_s)
    else $error("command inside refresh time");
  a_sleep_idle: assert property ($fell(cke_out) |-> open_r == 4'h0)
    else $error("sleep with a bank open");
  a_sleep_quiet: assert property (!cke_out && !$past(cke_out) |-> quiet)
    else $error("command while clock gated");
  a_sr_entry: assert property (is_ref && !cke_out |-> ##[0:1] in_self_refresh_out)
    else $error("self-refresh flag missing");
  a_sr_exit: assert property ($rose(cke_out) && sr_r |-> rest5_s)
    else $error("command too early after self-refresh");
  a_pd_exit: assert property ($rose(cke_out) && !sr_r |-> quiet [*2])
    else $error("command too early after power-down");
  a_write_oe: assert property (dq_oe_out |-> cmd == sdrrpm_pkg::CMD_WRITE)
    else $error("data driven outside a write");
endmodule : sdrrpm_ctrl_assertions
bind sdrrpm_ctrl sdrrpm_ctrl_assertions u_chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .cs_n_out(cs_n_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .we_n_out(we_n_out),
  .cke_out(cke_out), .ba_out(ba_out), .addr_out(addr_out), .dq_oe_out(dq_oe_out),
  .in_self_refresh_out(in_self_refresh_out));
`default_nettype wire

/* File: verif/sdrrpm_dev_model.sv */
// Behavioural memory module: commands, refresh, self-refresh and masks
`default_nettype none
module sdrrpm_dev_model (
  input wire logic sys_clk_in,
  input wire logic [3:0] cmd_in,
  input wire logic cke_in,
  input wire logic [1:0] ba_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] mask_in,
  input wire logic [63:0] dq_in,
  output logic [63:0] dq_out,
  output logic self_ref_out,
  output logic [11:0] row_out,
  output logic [7:0] err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cke_q = 1'b1, sr_flag = 1'b0, rd_q = 1'b0;
  logic [3:0] open_r = 4'h0;
  logic [1:0] ra_q = 2'h0;
  logic [7:0] mq = 8'hFF;
  logic [11:0] ref_rows = 12'h000, sr_rows = 12'h000;
  logic [63:0] mem [0:3] = '{default: 64'h0};
  initial err_out = 8'h00;
  initial dq_out = 64'h0;
  // Clock-gate rise ends self-refresh at once
  assign self_ref_out = sr_flag && !cke_in;
  assign row_out = ref_rows + sr_rows;
  // Internal refresh timer while self-refreshing
  always #2000 if (self_ref_out) sr_rows = sr_rows + 12'h001;
  // Command decode; a cycle after a low clock-gate sample is suspended
  always @(posedge sys_clk_in) begin
    cke_q <= cke_in;
    rd_q <= 1'b0;
    mq <= mask_in;
    if (sr_flag && cke_in) sr_flag <= 1'b0;
    if (cke_q && !self_ref_out) begin
      case (cmd_in)
        sdrrpm_pkg::CMD_REFRESH: begin
          if (open_r != 4'h0) err_out <= err_out + 8'h01;
          if (cke_in) ref_rows <= ref_rows + 12'h001;
          else sr_flag <= 1'b1;
        end
        sdrrpm_pkg::CMD_ACTIVATE: open_r[ba_in] <= 1'b1;
        sdrrpm_pkg::CMD_PRECHARGE: open_r <= addr_in[10] ? 4'h0 : open_r & ~(4'h1 << ba_in);
        sdrrpm_pkg::CMD_WRITE: for (int i = 0; i < 8; i++)
          if (!mask_in[i]) mem[addr_in[1:0]][8*i+:8] <= dq_in[8*i+:8];
        sdrrpm_pkg::CMD_READ: begin
          rd_q <= 1'b1;
          ra_q <= addr_in[1:0];
        end
        default: ;
      endcase
    end
    // Read data shows at the second edge; masked or idle bytes float (inverted)
    for (int i = 0; i < 8; i++)
      dq_out[8*i+:8] <= !rd_q ? ~dq_out[8*i+:8] :
        (mq[i] ? ~mem[ra_q][8*i+:8] : mem[ra_q][8*i+:8]);
  end
endmodule : sdrrpm_dev_model
`default_nettype wire

/* File: verif/sdrrpm_ctrl_test.sv */
// Testbench for the refresh and power-down controller
`default_nettype none
module sdrrpm_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, sr_req = 1'b0, pd_req = 1'b0;
  logic ready, cs_n, ras_n, cas_n, we_n, cke, oe, in_sr, in_pd, dev_sr;
  logic [2:0] req_cmd = 3'h0;
  logic [1:0] bank = 2'h0, ba;
  logic [11:0] addr = 12'h000, a_out, row, r0;
  logic [63:0] wdata = 64'h0, dq_c, dq_d, rdata;
  logic [7:0] wmask = 8'h00, rmask = 8'h00, bmask, dev_err;
  logic [3:0] pins;
  int failures = 0, comparisons = 0, n;
  assign pins = {cs_n, ras_n, cas_n, we_n};
  sdrrpm_ctrl dut (.sys_clk_in(clk), .reset_in(rst), .req_cmd_in(req_cmd),
    .req_valid_in(req_valid), .req_bank_in(bank), .req_addr_in(addr), .wr_data_in(wdata),
    .wr_mask_in(wmask), .rd_mask_in(rmask), .self_refresh_req_in(sr_req),
    .power_down_req_in(pd_req), .dq_in(dq_d), .req_ready_out(ready), .cs_n_out(cs_n),
    .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .cke_out(cke), .ba_out(ba),
    .addr_out(a_out), .byte_lane_mask_out(bmask), .dq_out(dq_c), .dq_oe_out(oe),
    .rd_data_out(rdata), .in_self_refresh_out(in_sr), .in_power_down_out(in_pd));
  sdrrpm_dev_model u_dev (.sys_clk_in(clk), .cmd_in(pins), .cke_in(cke), .ba_in(ba),
    .addr_in(a_out), .mask_in(bmask), .dq_in(dq_c), .dq_out(dq_d), .self_ref_out(dev_sr),
    .row_out(row), .err_out(dev_err));
  initial forever #10 clk = ~clk;
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Hold a request until taken; retry until it shows on the pins
  task automatic do_req(input logic [2:0] c, input logic [3:0] pin, input logic [1:0] b,
                        input logic [11:0] a);
    for (int t = 0; t < 8; t++) begin
      @(negedge clk);
      {req_cmd, bank, addr, req_valid} = {c, b, a, 1'b1};
      for (int w = 0; w < 50 && ready !== 1'b1; w++) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      if (pins === pin) return;
    end
    check(pins, pin);
  endtask : do_req
  task automatic wait_for(ref logic s);
    for (int w = 0; w < 900 && s !== 1'b1; w++) @(negedge clk);
    @(negedge clk);
  endtask : wait_for
  task automatic t_data();
    do_req(sdrrpm_pkg::REQ_MODE_SET, sdrrpm_pkg::CMD_MODE_SET, 2'h0, 12'h020);
    do_req(sdrrpm_pkg::REQ_ACTIVATE, sdrrpm_pkg::CMD_ACTIVATE, 2'h0, 12'h001);
    do_req(sdrrpm_pkg::REQ_ACTIVATE, sdrrpm_pkg::CMD_ACTIVATE, 2'h1, 12'h001);
    wdata = {16{4'h1}};
    do_req(sdrrpm_pkg::REQ_WRITE, sdrrpm_pkg::CMD_WRITE, 2'h0, 12'h002);
    {wdata, wmask} = {{16{4'hA}}, 8'hF0};
    do_req(sdrrpm_pkg::REQ_WRITE, sdrrpm_pkg::CMD_WRITE, 2'h0, 12'h002);
    check({oe, bmask, dq_c}, {1'b1, 8'hF0, {16{4'hA}}});
    for (int k = 0; k < 2; k++) begin
      rmask = k ? 8'h0F : 8'h00;
      do_req(sdrrpm_pkg::REQ_READ, sdrrpm_pkg::CMD_READ, 2'h0, 12'h002);
      repeat (3) @(negedge clk);
      check(rdata, {{8{4'h1}}, k ? {8{4'h5}} : {8{4'hA}}});
    end
    rmask = 8'h00;
    do_req(sdrrpm_pkg::REQ_PRECHARGE, sdrrpm_pkg::CMD_PRECHARGE, 2'h0, 12'h400);
    $display("test data done");
  endtask : t_data
  task automatic t_refresh();
    {n, r0} = {32'h0, row};
    repeat (1600) begin
      @(negedge clk);
      if (pins === sdrrpm_pkg::CMD_REFRESH && cke === 1'b1) n++;
    end
    check(n >= 2, 1'b1);
    check({row - r0, dev_err}, {n[11:0], 8'h00});
    $display("test refresh done");
  endtask : t_refresh
  task automatic t_self();
    sr_req = 1'b1;
    wait_for(in_sr);
    r0 = row;
    check({in_sr, cke, dev_sr}, 3'b101);
    repeat (300) @(negedge clk);
    check({row != r0, pins[3] || pins === sdrrpm_pkg::CMD_NOP}, 2'b11);
    sr_req = 1'b0;
    wait_for(ready);
    check({in_sr, cke, dev_sr}, 3'b010);
    $display("test self-refresh done");
  endtask : t_self
  task automatic t_power();
    pd_req = 1'b1;
    wait_for(in_pd);
    {req_cmd, bank, req_valid} = {sdrrpm_pkg::REQ_ACTIVATE, 2'h2, 1'b1};
    repeat (20) @(negedge clk);
    check({in_pd, cke, pins[3] || pins === sdrrpm_pkg::CMD_NOP}, 3'b101);
    {req_valid, pd_req} = 2'b00;
    do_req(sdrrpm_pkg::REQ_ACTIVATE, sdrrpm_pkg::CMD_ACTIVATE, 2'h2, 12'h003);
    do_req(sdrrpm_pkg::REQ_PRECHARGE, sdrrpm_pkg::CMD_PRECHARGE, 2'h0, 12'h400);
    check(dev_err, 8'h00);
    $display("test power-down done");
  endtask : t_power
  // Watchdog: all tests need about 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    check({pins, cke, bmask, oe}, {sdrrpm_pkg::CMD_NOP, 1'b1, 8'hFF, 1'b0});
    rst = 1'b0;
    t_data();
    t_refresh();
    t_self();
    t_power();
    summarize();
  end
endmodule : sdrrpm_ctrl_test
`default_nettype wire
